// file: dv/lbm_cfg_host.sv
`timescale 1ns/100ps
// user logic on the configuration port, one dword per access
module lbm_cfg_host (
	// clock and answer from the block
	input  wire logic        clk_i,
	input  wire logic        done_n_i,
	input  wire logic [31:0] do_i,
	// request side
	output logic      [9:0]  addr_o,
	output logic      [31:0] di_o,
	output logic      [3:0]  be_n_o,
	output logic             wr_n_o,
	output logic             rd_n_o
);
	// idle at time zero, no request pending
	initial begin
		addr_o = 10'h155;
		di_o   = 32'hA5A5_5A5A;
		be_n_o = 4'hF;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
	end

	// request held until done, then dropped before the next edge samples it
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
			output logic [31:0] q, output bit ok);
		int i;
		ok = 1'b0;
		q  = 32'h0;
		@(negedge clk_i);
		addr_o <= a;
		di_o   <= d;
		be_n_o <= 4'h0;
		wr_n_o <= !wr;
		rd_n_o <= wr;
		// bounded wait for the done pulse
		for (i = 0; i < 16 && !ok; i++) begin
			@(posedge clk_i);
			#1;
			if (done_n_i === 1'b0) begin
				ok = 1'b1;
				q  = do_i;
			end
		end
		@(negedge clk_i);
		wr_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		// released lines must not look like the last value
		addr_o <= ~addr_o;
		di_o   <= ~di_o;
		be_n_o <= 4'hF;
		// spacing: next request only once done has gone high again
		@(negedge clk_i);
	endtask : xfer
endmodule : lbm_cfg_host

// file: dv/test_link_loopback_master_test.sv
`timescale 1ns/100ps
module test_link_loopback_master_test import lbm_pkg::*;;
	localparam int TMO_SIM = 20;  // short answer timeout keeps the run brief
	logic             clk_i, rstn_i, slave, ts1, done_n, wr_n, rd_n;
	logic [5:0]       ltssm;      // link training state
	logic [7:0]       lane_act, lane_err;
	logic [9:0]       addr;
	logic [31:0]      di, dout, q;
	logic [31:0]      dout_alone; // read data of the layout without channels
	logic [3:0]       be_n;
	lbm_phy_t         phy;
	int               n_fail, n_tests;

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	lbm_vsec #(.VC_EN(1'b1), .VSEC_EN(1'b1), .TMO(TMO_SIM)) uut (
		.clk_i(clk_i), .rstn_i(rstn_i), .cfg_dwaddr_i(addr), .cfg_di_i(di),
		.cfg_byte_en_n_i(be_n), .cfg_wr_en_n_i(wr_n), .cfg_rd_en_n_i(rd_n),
		.cfg_do_o(dout), .cfg_rd_wr_done_n_o(done_n),
		.link_training_state_vector_i(ltssm), .slave_mode_i(slave),
		.ts1_lpbk_rx_i(ts1), .lane_active_i(lane_act), .lane_err_i(lane_err),
		.phy_ctl_o(phy));

	// second layout on the same port: serial number and vendor, no channels
	lbm_vsec #(.VC_EN(1'b0), .VSEC_EN(1'b1), .TMO(TMO_SIM)) uut_alone (
		.clk_i(clk_i), .rstn_i(rstn_i), .cfg_dwaddr_i(addr), .cfg_di_i(di),
		.cfg_byte_en_n_i(be_n), .cfg_wr_en_n_i(wr_n), .cfg_rd_en_n_i(rd_n),
		.cfg_do_o(dout_alone), .cfg_rd_wr_done_n_o(),
		.link_training_state_vector_i(ltssm), .slave_mode_i(slave),
		.ts1_lpbk_rx_i(ts1), .lane_active_i(lane_act), .lane_err_i(lane_err),
		.phy_ctl_o());

	lbm_cfg_host host (.clk_i(clk_i), .done_n_i(done_n), .do_i(dout), .addr_o(addr),
		.di_o(di), .be_n_o(be_n), .wr_n_o(wr_n), .rd_n_o(rd_n));

	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	// one access; a lost done pulse ends the run
	task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
		bit ok;
		host.xfer(wr, a, d, q, ok);
		if (!ok) begin
			n_fail++;
			print_verdict();
		end
	endtask : acc

	task automatic cycles(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cycles

	// reset values and the capability chain
	task automatic t_map();
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 10'(10'h4C + i), 32'h0);
			chk(q, 32'h0, "reset value");
		end
		acc(1'b0, 10'h4A, 32'h0);
		chk(q, 32'h0001_000B, "vendor header");
		chk(dout_alone, 32'h0, "no vendor at shared base");
		acc(1'b0, 10'h4B, 32'h0);
		chk(q, 32'h0180_0000, "vendor length");
		acc(1'b0, 10'h40, 32'h0);
		chk(q, 32'h10C1_0003, "serial header");
		chk(dout_alone, 32'h10C1_0003, "serial header alone");
		acc(1'b0, 10'h43, 32'h0);
		chk(q, 32'h1281_0002, "channel header");
		chk(dout_alone, 32'h0001_000B, "vendor base alone");
		acc(1'b0, 10'h60, 32'h0);
		chk(q, 32'h0, "unmapped read");
		acc(1'b1, 10'h4C, 32'hFFFF_FF7C);
		acc(1'b0, 10'h4C, 32'h0);
		chk(q, 32'h7C, "reserved bits");
		acc(1'b1, 10'h4C, 32'h0);
	endtask : t_map

	// armed outside L0, then a full run with staggered lane errors
	task automatic t_run();
		lane_act <= 8'h3F;
		acc(1'b1, 10'h4C, 32'h79);
		cycles(4);
		chk({31'h0, phy.master}, 32'h0, "master before L0");
		ltssm <= LTSSM_L0;
		cycles(4);
		chk({31'h0, phy.master}, 32'h1, "master in L0");
		chk({30'h0, phy.speed}, 32'h2, "speed");
		chk({31'h0, phy.deemph}, 32'h1, "deemphasis");
		chk({31'h0, phy.mod_compl}, 32'h1, "modified compliance");
		chk({31'h0, phy.skp_off}, 32'h1, "skip suppress");
		for (int i = 0; i < 4; i++) begin
			lane_err <= 8'hFF << i;
			cycles(1);
		end
		lane_err <= 8'h00;
		cycles(30);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h2, "slave failed");
		acc(1'b1, 10'h4C, 32'h0);
		cycles(2);
		chk({31'h0, phy.master}, 32'h0, "master left");
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h3F02, "tested flags");
		acc(1'b0, 10'h4E, 32'h0);
		chk(q, 32'h0403_0201, "low counts");
		acc(1'b0, 10'h4F, 32'h0);
		chk(q, 32'h0000_0404, "high counts");
		ltssm <= 6'h00;
		acc(1'b1, 10'h4C, 32'h1);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h0, "start clears status");
		acc(1'b0, 10'h4E, 32'h0);
		chk(q, 32'h0, "start clears counts");
		acc(1'b1, 10'h4C, 32'h0);
	endtask : t_run

	// force never reports a failed slave, nor does a received TS1
	task automatic t_force();
		ltssm <= LTSSM_L0;
		acc(1'b1, 10'h4C, 32'h3);
		cycles(4);
		chk({31'h0, phy.force_en}, 32'h1, "force out");
		cycles(30);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h0, "no fail under force");
		acc(1'b1, 10'h4C, 32'h0);
		acc(1'b1, 10'h4C, 32'h1);
		cycles(4);
		ts1 <= 1'b1;
		cycles(1);
		ts1 <= 1'b0;
		cycles(30);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h0, "no fail after TS1");
		acc(1'b1, 10'h4C, 32'h0);
	endtask : t_force

	// slave indication, refused start, then a reset while no test runs
	task automatic t_slave();
		slave <= 1'b1;
		cycles(2);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h3F01, "slave flag");
		acc(1'b1, 10'h4C, 32'h1);
		acc(1'b0, 10'h4C, 32'h0);
		chk(q, 32'h0, "start while slave");
		slave <= 1'b0;
		rstn_i <= 1'b0;
		cycles(3);
		rstn_i <= 1'b1;
		cycles(1);
		acc(1'b0, 10'h4D, 32'h0);
		chk(q, 32'h0, "status after reset");
	endtask : t_slave

	// main sequence: test runs while the application is idle
	initial begin
		clk_i    = 1'b0;
		rstn_i   = 1'b0;
		ltssm    = 6'h00;
		slave    = 1'b0;
		ts1      = 1'b0;
		lane_act = 8'h00;
		lane_err = 8'h00;
		n_fail   = 0;
		n_tests  = 0;
		cycles(16);
		rstn_i <= 1'b1;
		cycles(1);
		t_map();
		t_run();
		t_force();
		t_slave();
		print_verdict();
	end
endmodule : test_link_loopback_master_test

// file: rtl/lbm_pkg.sv
// Summary of operation
// - capability bases depend on which are enabled
// - chain order: serial, virtual channel, vendor
// - vendor header: 000Bh, v1, length 24
// - start written in L0 enters loopback master
// - start cleared leaves loopback master
// - force pushes unlocked slave into loopback
// - bits 3:2 give advertised loopback speed
// - bit 4 gives de-emphasis, slave too
// - bit 5 selects modified compliance, one SKP
// - bit 6 suppresses SKP, needs bit 5
// - status bit 0 shows device is slave
// - no loopback TS1 in 100 ms, force off: slave failed
// - start clears slave-failed flag
// - per-lane tested flags, cleared by start
// - 8-bit lane counts packed in two registers
// - code or disparity error bumps lane count
// - start clears every lane count
// - lane counts read out unmasked by tested flags
package lbm_pkg;
	localparam int          LANES         = 8;
	// capability byte bases, dword address is base / 4
	localparam logic [11:0] DSN_BASE_B    = 12'h100;
	localparam logic [11:0] VC_BASE_B     = 12'h10C;
	localparam logic [11:0] VSEC_ALONE_B  = 12'h10C;
	localparam logic [11:0] VSEC_ALL_B    = 12'h128;
	localparam logic [11:0] NO_NEXT_B     = 12'h000;
	// offsets inside the vendor structure, in bytes
	localparam logic [11:0] OFS_HDR       = 12'h000;
	localparam logic [11:0] OFS_VHDR      = 12'h004;
	localparam logic [11:0] OFS_CTRL      = 12'h008;
	localparam logic [11:0] OFS_STAT      = 12'h00C;
	localparam logic [11:0] OFS_ERR_LO    = 12'h010;
	localparam logic [11:0] OFS_ERR_HI    = 12'h014;
	// header fields
	localparam logic [15:0] ECAP_ID_VSEC  = 16'h000B;
	localparam logic [15:0] ECAP_ID_DSN   = 16'h0003;
	localparam logic [15:0] ECAP_ID_VC    = 16'h0002;
	localparam logic [3:0]  ECAP_VER      = 4'h1;
	localparam logic [11:0] VSEC_LEN      = 12'h018;
	localparam logic [3:0]  VSEC_REV      = 4'h0;
	localparam logic [15:0] VSEC_ID       = 16'h0000;
	// link training code for L0
	localparam logic [5:0]  LTSSM_L0      = 6'h16;
	// control and status field layout
	localparam int          CTL_W         = 7;
	localparam int          STAT_TESTED   = 8;
	localparam logic [7:0]  CNT_MAX       = 8'hFF;
	// slave answer timeout
	localparam int          TMO_MS        = 100;
	localparam int          CLK_MHZ       = 100;
	localparam int          TMO_CYC       = TMO_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		LBM_IDLE   = 2'b00,  // no test
		LBM_ARMED  = 2'b01,  // start set, waiting for L0
		LBM_ACTIVE = 2'b10   // loopback master running
	} lbm_fsm_t;

	// control register image, bit 0 at the bottom
	typedef struct packed {
		logic       no_skp;     // bit 6
		logic       mod_compl;  // bit 5
		logic       deemph;     // bit 4
		logic [1:0] speed;      // bits 3:2
		logic       force_en;   // bit 1
		logic       start;      // bit 0
	} lbm_ctl_t;

	// what the physical layer is told to do
	typedef struct packed {
		logic       master;
		logic       force_en;
		logic [1:0] speed;
		logic       deemph;
		logic       mod_compl;
		logic       skp_off;
	} lbm_phy_t;

	// whole state of the block
	typedef struct packed {
		lbm_fsm_t              fsm;
		lbm_ctl_t              ctl;
		logic                  fail;
		logic [LANES-1:0]      tested;
		logic [LANES-1:0][7:0] cnt;
		logic [23:0]           tmr;
		logic                  ts1_seen;
		logic [31:0]           rd_data;
		logic                  done;
		lbm_phy_t              phy;
	} lbm_state_t;
endpackage : lbm_pkg

// file: rtl/lbm_vsec.sv
`timescale 1ns/100ps
module lbm_vsec import lbm_pkg::*; #(
	parameter bit VC_EN   = 1'b1,      // virtual channel present
	parameter bit VSEC_EN = 1'b1,      // vendor structure present
	parameter int TMO     = TMO_CYC    // slave answer timeout, cycles
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	// configuration management port
	input  wire logic [9:0]            cfg_dwaddr_i,
	input  wire logic [31:0]           cfg_di_i,
	input  wire logic [3:0]            cfg_byte_en_n_i,
	input  wire logic                  cfg_wr_en_n_i,
	input  wire logic                  cfg_rd_en_n_i,
	output logic      [31:0]           cfg_do_o,
	output logic                       cfg_rd_wr_done_n_o,
	// link status from the physical layer
	input  wire logic [5:0]            link_training_state_vector_i,
	input  wire logic                  slave_mode_i,
	input  wire logic                  ts1_lpbk_rx_i,
	input  wire logic [LANES-1:0]      lane_active_i,
	input  wire logic [LANES-1:0]      lane_err_i,
	// loopback master controls to the physical layer
	output lbm_phy_t                   phy_ctl_o
);
	// byte base and next pointers in bytes, then dword addresses of each register
	localparam logic [11:0] VSEC_B  = VC_EN ? VSEC_ALL_B : VSEC_ALONE_B;
	localparam logic [11:0] DSN_NX  = VC_EN ? VC_BASE_B :
	                                  (VSEC_EN ? VSEC_B : NO_NEXT_B);
	localparam logic [11:0] VC_NX   = VSEC_EN ? VSEC_B : NO_NEXT_B;
	localparam logic [9:0]  A_DSN   = DSN_BASE_B[11:2];
	localparam logic [9:0]  A_VC    = VC_BASE_B[11:2];
	localparam logic [9:0]  A_HDR   = VSEC_B[11:2] + OFS_HDR[11:2];
	localparam logic [9:0]  A_VHDR  = VSEC_B[11:2] + OFS_VHDR[11:2];
	localparam logic [9:0]  A_CTRL  = VSEC_B[11:2] + OFS_CTRL[11:2];
	localparam logic [9:0]  A_STAT  = VSEC_B[11:2] + OFS_STAT[11:2];
	localparam logic [9:0]  A_ELO   = VSEC_B[11:2] + OFS_ERR_LO[11:2];
	localparam logic [9:0]  A_EHI   = VSEC_B[11:2] + OFS_ERR_HI[11:2];
	localparam logic [23:0] TMO_END = 24'(TMO - 1);

	lbm_state_t            st_ff;      // registered state
	lbm_state_t            nxt_st;     // next state
	logic                  wr_req;     // write taken this cycle
	logic                  rd_req;     // read taken this cycle
	logic                  start_evt;  // start bit newly set
	logic [LANES-1:0][7:0] cnt_step;   // per-lane count plus error
	logic [31:0]           rd_mux;     // read data selection
	lbm_ctl_t              wr_ctl;     // control image after write

	// one request per handshake; the cycle that shows done is blocked since the
	// user still holds the enable while it sees done
	assign wr_req = !cfg_wr_en_n_i && !st_ff.done;
	assign rd_req = !cfg_rd_en_n_i && cfg_wr_en_n_i && !st_ff.done;

	// control write: only byte 0 holds live bits, the rest is dropped
	always_comb begin
		wr_ctl = st_ff.ctl;
		if (wr_req && cfg_dwaddr_i == A_CTRL && !cfg_byte_en_n_i[0]) begin
			wr_ctl = lbm_ctl_t'(cfg_di_i[CTL_W-1:0]);
			// a slave cannot also be master, so start is refused
			if (slave_mode_i && !st_ff.ctl.start) begin
				wr_ctl.start = 1'b0;
			end
		end
	end

	// start counts only on its rising write, a rewrite of one is quiet
	assign start_evt = wr_ctl.start && !st_ff.ctl.start;

	// per-lane error counters, saturating so a noisy lane never wraps to 0
	generate
		for (genvar l = 0; l < LANES; l++) begin : g_lane
			always_comb begin
				cnt_step[l] = st_ff.cnt[l];
				if (st_ff.fsm == LBM_ACTIVE && lane_active_i[l] &&
				    lane_err_i[l] && st_ff.cnt[l] != CNT_MAX) begin
					cnt_step[l] = st_ff.cnt[l] + 8'h01;
				end
			end
		end
	endgenerate

	// read decode; unmapped dwords answer zero
	always_comb begin
		unique case (cfg_dwaddr_i)
			A_DSN:   rd_mux = {DSN_NX, ECAP_VER, ECAP_ID_DSN};
			A_HDR:   rd_mux = VSEC_EN ? {NO_NEXT_B, ECAP_VER, ECAP_ID_VSEC}
			                          : 32'h0;
			A_VHDR:  rd_mux = VSEC_EN ? {VSEC_LEN, VSEC_REV, VSEC_ID} : 32'h0;
			A_CTRL:  rd_mux = {25'h0, st_ff.ctl};
			A_STAT:  rd_mux = {16'h0, st_ff.tested, 6'h0,
			                   st_ff.fail, slave_mode_i};
			A_ELO:   rd_mux = {st_ff.cnt[3], st_ff.cnt[2],
			                   st_ff.cnt[1], st_ff.cnt[0]};
			A_EHI:   rd_mux = {st_ff.cnt[7], st_ff.cnt[6],
			                   st_ff.cnt[5], st_ff.cnt[4]};
			default: rd_mux = 32'h0;
		endcase
		// without channels the vendor header takes this dword, so the channel
		// header is decoded apart and only when it exists
		if (VC_EN && cfg_dwaddr_i == A_VC) begin
			rd_mux = {VC_NX, ECAP_VER, ECAP_ID_VC};
		end
	end

	// next state
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.ctl     = wr_ctl;
		nxt_st.cnt     = cnt_step;
		nxt_st.done    = wr_req || rd_req;
		// read data is held until the next read answers
		if (rd_req) begin
			nxt_st.rd_data = rd_mux;
		end
		unique case (st_ff.fsm)
			LBM_IDLE: begin
				if (start_evt) begin
					nxt_st.fsm = LBM_ARMED;
				end
			end
			LBM_ARMED: begin
				// entry waits for L0 so a start during training is not lost
				if (!wr_ctl.start) begin
					nxt_st.fsm = LBM_IDLE;
				end else if (link_training_state_vector_i == LTSSM_L0) begin
					nxt_st.fsm      = LBM_ACTIVE;
					nxt_st.tmr      = 24'h0;
					nxt_st.ts1_seen = 1'b0;
				end
			end
			LBM_ACTIVE: begin
				if (ts1_lpbk_rx_i) begin
					nxt_st.ts1_seen = 1'b1;
				end
				if (st_ff.tmr != TMO_END) begin
					nxt_st.tmr = st_ff.tmr + 24'h1;
				end else if (!st_ff.ts1_seen && !ts1_lpbk_rx_i &&
				             !st_ff.ctl.force_en) begin
					nxt_st.fail = 1'b1;
				end
				if (!wr_ctl.start) begin
					// counts become valid once the lane ran the test
					nxt_st.fsm    = LBM_IDLE;
					nxt_st.tested = st_ff.tested | lane_active_i;
				end
			end
			default: nxt_st.fsm = LBM_IDLE;
		endcase
		// a new start wipes the results of the previous test
		if (start_evt) begin
			nxt_st.fail   = 1'b0;
			nxt_st.tested = '0;
			nxt_st.cnt    = '0;
		end
		// controls go out registered, taken from the next image
		nxt_st.phy.master    = (nxt_st.fsm == LBM_ACTIVE);
		nxt_st.phy.force_en  = wr_ctl.force_en;
		nxt_st.phy.speed     = wr_ctl.speed;
		nxt_st.phy.deemph    = wr_ctl.deemph;
		nxt_st.phy.mod_compl = wr_ctl.mod_compl;
		nxt_st.phy.skp_off   = wr_ctl.no_skp && wr_ctl.mod_compl;
	end

	// state register; reset leaves no test and empty results
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cfg_do_o           = st_ff.rd_data;
	assign cfg_rd_wr_done_n_o = !st_ff.done;
	assign phy_ctl_o          = st_ff.phy;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic [9:0] chk_addr_ff;   // address of the last taken request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chk_addr_ff <= 10'h0;
		end else if (wr_req || rd_req) begin
			chk_addr_ff <= cfg_dwaddr_i;
		end
	end

	a_enter_master: assert property (
		st_ff.fsm == LBM_ARMED && wr_ctl.start &&
		link_training_state_vector_i == LTSSM_L0 |=> phy_ctl_o.master)
		else $error("master not entered from L0");
	a_leave_master: assert property (
		st_ff.fsm == LBM_ACTIVE && !wr_ctl.start |=> !phy_ctl_o.master)
		else $error("master not left after start cleared");
	a_start_clears: assert property (
		start_evt |=> st_ff.cnt == '0 && st_ff.tested == '0 && !st_ff.fail)
		else $error("start did not clear results");
	a_fail_no_force: assert property (
		$rose(st_ff.fail) |-> $past(st_ff.ctl.force_en) == 1'b0 &&
		$past(st_ff.tmr) == TMO_END)
		else $error("slave failed set at wrong time");
	a_skp_gated: assert property (
		phy_ctl_o.skp_off |-> phy_ctl_o.mod_compl)
		else $error("skp suppressed without modified compliance");
	a_err_count: assert property (
		st_ff.fsm == LBM_ACTIVE && lane_active_i[0] && lane_err_i[0] &&
		st_ff.cnt[0] != CNT_MAX && !start_evt |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 8'h01)
		else $error("lane 0 error not counted");
	a_idle_lane: assert property (
		!lane_active_i[1] && !start_evt |=> st_ff.cnt[1] == $past(st_ff.cnt[1]))
		else $error("inactive lane counted");
	a_ctrl_rsvd: assert property (
		!cfg_rd_wr_done_n_o && chk_addr_ff == A_CTRL && $past(rd_req) |->
		cfg_do_o[31:CTL_W] == '0)
		else $error("control reserved bits not zero");
	a_slave_start: assert property (
		slave_mode_i && st_ff.fsm == LBM_IDLE && !st_ff.ctl.start |=> !st_ff.ctl.start)
		else $error("start taken while slave");

	c_test_run:  cover property (st_ff.fsm == LBM_ACTIVE ##1 st_ff.fsm == LBM_IDLE);
	c_fail:      cover property ($rose(st_ff.fail));
	c_lane_err:  cover property (st_ff.cnt[0] != 8'h00 && st_ff.tested[0]);
	c_armed:     cover property (st_ff.fsm == LBM_ARMED ##1 st_ff.fsm == LBM_ARMED);
endmodule : lbm_vsec
